/* rtl/rcr_pkg.sv */
// Shared constants and carrier types for the reset cause recorder.
// Assumes one 50 MHz core clock and an AXI4-Lite register port.
package rcr_pkg;

  localparam int PC_W = 13;
  localparam int IRQ_W = 7;

  // Register byte offsets
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h00;
  localparam logic [7:0] OFS_CORE_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

  // Reset cause register fields
  localparam int CAUSE_BOR_BIT = 0;
  localparam int CAUSE_POR_BIT = 1;
  localparam int CAUSE_OK_BIT = 2;
  localparam int CAUSE_HIST_BIT = 3;
  localparam int CAUSE_REF_BIT = 7;
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [7:0] CAUSE_IMPL_MASK = 8'h8F;

  // Core status register: bits 4 and 3 belong to hardware only
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] STATUS_SW_MASK = 8'hE7;

  // Status update masks, new = (old & keep) | set
  localparam logic [7:0] KEEP_POWER = 8'h07;
  localparam logic [7:0] SET_POWER = 8'h18;
  localparam logic [7:0] KEEP_PIN_RUN = 8'h1F;
  localparam logic [7:0] SET_PIN_RUN = 8'h00;
  localparam logic [7:0] KEEP_PIN_SLEEP = 8'h17;
  localparam logic [7:0] SET_PIN_SLEEP = 8'h10;
  localparam logic [7:0] KEEP_WDT_RESET = 8'h0F;
  localparam logic [7:0] SET_WDT_RESET = 8'h00;
  localparam logic [7:0] KEEP_WDT_WAKE = 8'hE7;
  localparam logic [7:0] SET_WDT_WAKE = 8'h00;
  localparam logic [7:0] KEEP_IRQ_WAKE = 8'hF7;
  localparam logic [7:0] SET_IRQ_WAKE = 8'h10;

  // Program counter targets
  localparam logic [PC_W-1:0] PC_RESTART = 13'h0000;
  localparam logic [PC_W-1:0] PC_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset and wake sources, one-cycle pulses
  typedef struct packed {
    logic irq_wake;
    logic wdt_wake;
    logic wdt_reset;
    logic pin_reset;
    logic bor;
    logic por;
  } rcr_event_type;

  typedef struct packed {
    logic hit;
    logic restart;
    logic resume;
    logic irq_wake;
    logic clr_por;
    logic clr_bor;
    logic [7:0] keep;
    logic [7:0] set;
  } rcr_action_type;

  typedef struct packed {
    logic load;
    logic push;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] ret;
  } rcr_pc_cmd_type;

  typedef enum logic [1:0] {
    RCR_RUN = 2'b00,
    RCR_EXEC_ONE = 2'b01
  } rcr_fsm_type;

  typedef struct packed {
    logic aw_have;
    logic w_have;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic wr_pulse;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } rcr_axil_state_type;

endpackage

/* rtl/rcr_event_decode.sv */
// Priority decoder from reset and wake sources to status updates.
// Assumes at most one source per cycle; otherwise the top one wins.
`timescale 1ns/1ns
`default_nettype none
module rcr_event_decode (
  // Sources
  input wire rcr_pkg::rcr_event_type ev,
  input wire logic asleep,
  // Decoded action
  output rcr_pkg::rcr_action_type act
);

  always_comb begin
    act = '0;
    act.keep = 8'hFF;
    if (ev.por) begin
      act.hit = 1'b1;
      act.restart = 1'b1;
      act.clr_por = 1'b1;
      act.keep = rcr_pkg::KEEP_POWER;
      act.set = rcr_pkg::SET_POWER;
    end else if (ev.bor) begin
      act.hit = 1'b1;
      act.restart = 1'b1;
      act.clr_bor = 1'b1;
      act.keep = rcr_pkg::KEEP_POWER;
      act.set = rcr_pkg::SET_POWER;
    end else if (ev.pin_reset && asleep) begin
      act.hit = 1'b1;
      act.restart = 1'b1;
      act.keep = rcr_pkg::KEEP_PIN_SLEEP;
      act.set = rcr_pkg::SET_PIN_SLEEP;
    end else if (ev.pin_reset) begin
      act.hit = 1'b1;
      act.restart = 1'b1;
      act.keep = rcr_pkg::KEEP_PIN_RUN;
      act.set = rcr_pkg::SET_PIN_RUN;
    end else if (ev.wdt_reset) begin
      act.hit = 1'b1;
      act.restart = 1'b1;
      act.keep = rcr_pkg::KEEP_WDT_RESET;
      act.set = rcr_pkg::SET_WDT_RESET;
    end else if (ev.wdt_wake) begin
      act.hit = 1'b1;
      act.resume = 1'b1;
      act.keep = rcr_pkg::KEEP_WDT_WAKE;
      act.set = rcr_pkg::SET_WDT_WAKE;
    end else if (ev.irq_wake) begin
      act.hit = 1'b1;
      act.resume = 1'b1;
      act.irq_wake = 1'b1;
      act.keep = rcr_pkg::KEEP_IRQ_WAKE;
      act.set = rcr_pkg::SET_IRQ_WAKE;
    end
  end

endmodule
`default_nettype wire

/* rtl/rcr_axil.sv */
// AXI4-Lite slave front end, one write and one read at a time.
// Assumes the parent decodes addresses and supplies read data.
`timescale 1ns/1ns
`default_nettype none
module rcr_axil (
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output logic wr_pulse,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic wr_lane0,
  input wire logic wr_hit,
  input wire logic rd_hit,
  input wire logic [7:0] rd_data
);

  rcr_pkg::rcr_axil_state_type q, d;

  always_comb begin
    d = q;
    d.wr_pulse = 1'b0;
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.waddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata[7:0];
      d.wstrb0 = s_axi_wstrb[0];
    end
    // Write lands one cycle after both halves are held
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_hit ? rcr_pkg::RESP_OKAY : rcr_pkg::RESP_SLVERR;
      d.wr_pulse = wr_hit && q.wstrb0;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd_data;
      d.rresp = rd_hit ? rcr_pkg::RESP_OKAY : rcr_pkg::RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = {24'h000000, q.rdata};
  assign wr_pulse = q.wr_pulse;
  assign wr_addr = q.waddr;
  assign wr_data = q.wdata;
  assign wr_lane0 = q.wstrb0;

endmodule
`default_nettype wire

/* rtl/rcr_top.sv */
// Reset cause recorder: core status and reset cause registers,
// restart and resume steering of the program counter, supply status.
// Assumes source pulses and supply levels are synchronous to clk.
//
// Notes on behaviour
// - Power-on clears power flag; brown-out clears brown flag; both set status bits.
// - After power or brown-out reset: start at zero, upper status reads 0001 1.
// - Pin reset while running: start at zero, clear top three status bits.
// - Pin reset while asleep: start at zero, set expired, clear sleep bit.
// - Watchdog reset clears top four bits; watchdog wake resumes, clears both.
// - Interrupt wake resumes next instruction, sets expired, clears sleep bit.
// - Interrupt wake with enable: run one instruction, push return, jump vector.
// - Cause register holds power-on flag in bit 1, brown-out in bit 0.
// - Bit 2 shows live supply regulation state.
// - Bit 3 clears when regulation drops and stays zero until firmware sets.
// - Bit 7 shows main supply above analog with converter reference present.
// - Unimplemented bits, including cause bits 6 to 4, read as zero.
`timescale 1ns/1ns
`default_nettype none
module rcr_top (
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reset and wake sources
  input wire rcr_pkg::rcr_event_type ev,
  input wire logic asleep,
  // Core side
  input wire logic global_irq_enable,
  input wire logic [rcr_pkg::PC_W-1:0] current_pc,
  input wire logic instr_retired,
  output rcr_pkg::rcr_pc_cmd_type pc_cmd,
  output logic [7:0] core_status,
  // Supply monitors
  input wire logic supply_in_regulation,
  input wire logic supply_main_above_analog,
  input wire logic converter_reference_present,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    rcr_pkg::rcr_fsm_type fsm;
    logic [7:0] cause;
    logic [7:0] status;
    logic [rcr_pkg::IRQ_W-1:0] irq_stat;
    logic [rcr_pkg::IRQ_W-1:0] irq_mask;
    logic irq;
    logic [rcr_pkg::PC_W-1:0] resume_pc;
    rcr_pkg::rcr_pc_cmd_type cmd;
  } rcr_top_state_type;

  rcr_top_state_type q, d;
  rcr_pkg::rcr_action_type act;
  logic wr_pulse;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_lane0;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] rd_data;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == rcr_pkg::OFS_RESET_CAUSE) || (a == rcr_pkg::OFS_CORE_STATUS)
      || (a == rcr_pkg::OFS_IRQ_STATUS) || (a == rcr_pkg::OFS_IRQ_MASK);
  endfunction

  rcr_event_decode u_decode (
    .ev(ev),
    .asleep(asleep),
    .act(act)
  );

  rcr_axil u_axil (
    .clk(clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_lane0(wr_lane0),
    .wr_hit(wr_hit),
    .rd_hit(rd_hit),
    .rd_data(rd_data)
  );

  assign wr_hit = addr_hit(wr_addr);
  assign rd_hit = addr_hit(s_axi_araddr[7:0]);

  // Read mux; unmapped offsets and unused bits return zero
  always_comb begin
    case (s_axi_araddr[7:0])
      rcr_pkg::OFS_RESET_CAUSE: rd_data = q.cause & rcr_pkg::CAUSE_IMPL_MASK;
      rcr_pkg::OFS_CORE_STATUS: rd_data = q.status;
      rcr_pkg::OFS_IRQ_STATUS: rd_data = {1'b0, q.irq_stat};
      rcr_pkg::OFS_IRQ_MASK: rd_data = {1'b0, q.irq_mask};
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    logic [rcr_pkg::IRQ_W-1:0] irq_set;
    logic [rcr_pkg::IRQ_W-1:0] irq_clr;
    logic sw_cause;
    logic sw_status;
    irq_set = '0;
    irq_clr = '0;
    sw_cause = wr_pulse && (wr_addr == rcr_pkg::OFS_RESET_CAUSE);
    sw_status = wr_pulse && (wr_addr == rcr_pkg::OFS_CORE_STATUS);
    d = q;
    d.cmd.load = 1'b0;
    d.cmd.push = 1'b0;

    // Software writes first, so hardware events below override them
    if (sw_status) begin
      d.status = (q.status & ~rcr_pkg::STATUS_SW_MASK) | (wr_data & rcr_pkg::STATUS_SW_MASK);
    end
    if (sw_cause) begin
      d.cause[rcr_pkg::CAUSE_POR_BIT] = wr_data[rcr_pkg::CAUSE_POR_BIT];
      d.cause[rcr_pkg::CAUSE_BOR_BIT] = wr_data[rcr_pkg::CAUSE_BOR_BIT];
      if (supply_in_regulation) begin
        d.cause[rcr_pkg::CAUSE_HIST_BIT] = wr_data[rcr_pkg::CAUSE_HIST_BIT];
      end
    end
    if (wr_pulse && (wr_addr == rcr_pkg::OFS_IRQ_MASK)) begin
      d.irq_mask = wr_data[rcr_pkg::IRQ_W-1:0];
    end
    if (wr_pulse && (wr_addr == rcr_pkg::OFS_IRQ_STATUS)) begin
      irq_clr = wr_data[rcr_pkg::IRQ_W-1:0];
    end

    // Reset and wake sources
    if (act.hit) begin
      d.status = (d.status & act.keep) | act.set;
    end
    if (act.clr_por) begin
      d.cause[rcr_pkg::CAUSE_POR_BIT] = 1'b0;
    end
    if (act.clr_bor) begin
      d.cause[rcr_pkg::CAUSE_BOR_BIT] = 1'b0;
    end

    // Live supply status and dropout history
    d.cause[rcr_pkg::CAUSE_OK_BIT] = supply_in_regulation;
    d.cause[rcr_pkg::CAUSE_REF_BIT] = supply_main_above_analog
      && converter_reference_present;
    d.cause[6:4] = 3'b000;
    if (!supply_in_regulation) begin
      d.cause[rcr_pkg::CAUSE_HIST_BIT] = 1'b0;
    end

    // Program counter steering
    case (q.fsm)
      rcr_pkg::RCR_RUN: begin
        if (act.restart) begin
          d.cmd.load = 1'b1;
          d.cmd.target = rcr_pkg::PC_RESTART;
        end else if (act.resume) begin
          d.cmd.load = 1'b1;
          d.cmd.target = current_pc + rcr_pkg::PC_STEP;
          d.resume_pc = current_pc + rcr_pkg::PC_STEP;
          if (act.irq_wake && global_irq_enable) begin
            d.fsm = rcr_pkg::RCR_EXEC_ONE;
          end
        end
      end
      rcr_pkg::RCR_EXEC_ONE: begin
        // A restart aborts the pending vector jump
        if (act.restart) begin
          d.cmd.load = 1'b1;
          d.cmd.target = rcr_pkg::PC_RESTART;
          d.fsm = rcr_pkg::RCR_RUN;
        end else if (instr_retired) begin
          d.cmd.load = 1'b1;
          d.cmd.push = 1'b1;
          d.cmd.ret = q.resume_pc + rcr_pkg::PC_STEP;
          d.cmd.target = rcr_pkg::PC_VECTOR;
          d.fsm = rcr_pkg::RCR_RUN;
        end
      end
      default: begin
        d.fsm = rcr_pkg::RCR_RUN;
      end
    endcase

    // Sticky events; a set in the clearing cycle survives
    irq_set = {q.cause[rcr_pkg::CAUSE_OK_BIT] && !supply_in_regulation,
      ev.irq_wake, ev.wdt_wake, ev.wdt_reset, ev.pin_reset, ev.bor, ev.por};
    d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.fsm <= rcr_pkg::RCR_RUN;
      q.cause <= rcr_pkg::CAUSE_RESET;
      q.status <= rcr_pkg::STATUS_RESET;
    end else begin
      q <= d;
    end
  end

  assign pc_cmd = q.cmd;
  assign core_status = q.status;
  assign irq = q.irq;

endmodule
`default_nettype wire

/* dv/rcr_top_chk.sv */
// Concurrent checks on status, restart and resume steering of rcr_top.
// Assumes the bench pulses at most one source per cycle.
`timescale 1ns/1ns
`default_nettype none
module rcr_top_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sources and core side
  input wire rcr_pkg::rcr_event_type ev,
  input wire logic asleep,
  input wire logic [rcr_pkg::PC_W-1:0] current_pc,
  input wire rcr_pkg::rcr_pc_cmd_type pc_cmd,
  input wire logic [7:0] core_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_por_status: assert property (
    ev.por |=> core_status[7:3] == 5'h03)
    else $error("power-on status wrong");
  chk_power_restart: assert property (
    (ev.por || ev.bor) |=> pc_cmd.load && !pc_cmd.push && pc_cmd.target == 13'h0000)
    else $error("power restart wrong");
  chk_bor_status: assert property (
    ev == 6'h02 |=> core_status == {5'h03, $past(core_status[2:0])})
    else $error("brown-out status wrong");
  chk_pin_running: assert property (
    ev == 6'h04 && !asleep |=> core_status == {3'h0, $past(core_status[4:0])}
      && pc_cmd.load && pc_cmd.target == 13'h0000)
    else $error("pin reset while running wrong");
  chk_pin_asleep: assert property (
    ev == 6'h04 && asleep |=> core_status == {5'h02, $past(core_status[2:0])}
      && pc_cmd.load && pc_cmd.target == 13'h0000)
    else $error("pin reset while asleep wrong");
  chk_wdt_reset: assert property (
    ev == 6'h08 |=> core_status == {4'h0, $past(core_status[3:0])} && pc_cmd.load)
    else $error("watchdog reset wrong");
  chk_wdt_wake: assert property (
    ev == 6'h10 |=> core_status == ($past(core_status) & 8'hE7)
      && pc_cmd.load && pc_cmd.target == $past(current_pc) + 13'h0001)
    else $error("watchdog wake wrong");
  chk_irq_wake: assert property (
    ev == 6'h20 |=> core_status == (($past(core_status) & 8'hF7) | 8'h10)
      && pc_cmd.target == $past(current_pc) + 13'h0001)
    else $error("interrupt wake wrong");
  chk_vector_jump: assert property (
    pc_cmd.push |-> pc_cmd.load && pc_cmd.target == 13'h0004 && !$past(pc_cmd.load))
    else $error("vector jump wrong");

  cover property (ev.por);
  cover property (ev == 6'h04 && asleep);
  cover property (pc_cmd.push);
endmodule
bind rcr_top rcr_top_chk u_chk (.clk, .rst, .ev, .asleep, .current_pc, .pc_cmd, .core_status);
`default_nettype wire

/* dv/rcr_top_test.sv */
// Self-checking bench for rcr_top: register access, sources, supply status.
// Assumes a set mask bit lets the matching status bit raise irq.
`timescale 1ns/1ns
`default_nettype none
module rcr_top_test;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, pb;
  rcr_pkg::rcr_event_type ev;
  rcr_pkg::rcr_pc_cmd_type pc_cmd;
  logic [rcr_pkg::PC_W-1:0] current_pc;
  logic asleep, global_irq_enable, instr_retired, irq, hist;
  logic supply_in_regulation, supply_main_above_analog, converter_reference_present;
  logic [7:0] core_status, exp_st;
  int fail_count, compares, cycles;
  logic [5:0] codes [7] = '{6'h01, 6'h02, 6'h04, 6'h04, 6'h08, 6'h10, 6'h20};
  logic [7:0] keeps [7] = '{8'h07, 8'h07, 8'h1F, 8'h17, 8'h0F, 8'hE7, 8'hF7};
  logic [7:0] sets [7] = '{8'h18, 8'h18, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10};
  logic [6:0] slp = 7'h68;
  logic [6:0] res = 7'h60;

  rcr_top uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ev, .asleep, .global_irq_enable, .current_pc, .instr_retired, .pc_cmd,
    .core_status, .supply_in_regulation, .supply_main_above_analog,
    .converter_reference_present, .irq);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict;
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Generous ceiling, the sequence needs well under two thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict;
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [31:0] cause_exp();
    return {24'h0, supply_main_above_analog & converter_reference_present, 3'h0, hist,
      supply_in_regulation, pb};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Live bits are registered, so let two edges pass before reading
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask

  task automatic pulse(input logic [5:0] c, input logic r);
    ev <= c;
    @(posedge clk);
    ev <= 6'h00;
    // Load is a one-cycle pulse launched by the edge that took the source
    #1;
    chk("pc load", 32'h1, 32'(pc_cmd.load));
    chk("pc target", r ? 32'(current_pc + 13'h0001) : 32'h0, 32'(pc_cmd.target));
    @(posedge clk);
  endtask

  initial begin
    rst = 1'b1;
    ev = 6'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    {asleep, global_irq_enable, instr_retired} = 3'h0;
    {supply_in_regulation, supply_main_above_analog, converter_reference_present} = 3'h7;
    current_pc = 13'h0000;
    {fail_count, compares, cycles} = 96'h0;
    exp_st = 8'h18;
    pb = 2'h0;
    hist = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdr(8'h00);
    chk("cause reset", cause_exp(), rd);
    rdr(8'h04);
    chk("status reset", 32'h18, rd);
    wr(8'h00, 8'hFF);
    {hist, pb} = 3'h7;
    rdr(8'h00);
    chk("cause all ones", cause_exp(), rd);
    supply_in_regulation <= 1'b0;
    settle;
    hist = 1'b0;
    wr(8'h00, 8'h0B);
    rdr(8'h00);
    chk("cause dropout", cause_exp(), rd);
    supply_in_regulation <= 1'b1;
    settle;
    rdr(8'h00);
    chk("cause history kept", cause_exp(), rd);
    wr(8'h00, 8'h0B);
    hist = 1'b1;
    converter_reference_present <= 1'b0;
    settle;
    rdr(8'h00);
    chk("cause no reference", cause_exp(), rd);
    converter_reference_present <= 1'b1;
    supply_main_above_analog <= 1'b0;
    settle;
    rdr(8'h00);
    chk("cause supply low", cause_exp(), rd);
    supply_main_above_analog <= 1'b1;
    settle;
    for (int i = 0; i < 7; i++) begin
      wr(8'h04, i[0] ? 8'hA5 : 8'h5A);
      exp_st = ((i[0] ? 8'hA5 : 8'h5A) & 8'hE7) | (exp_st & 8'h18);
      asleep <= slp[i];
      current_pc <= 13'h0100 + 13'(i);
      pulse(codes[i], res[i]);
      exp_st = (exp_st & keeps[i]) | sets[i];
      if (i == 0)
        pb[1] = 1'b0;
      if (i == 1)
        pb[0] = 1'b0;
      rdr(8'h04);
      chk("status after source", {24'h0, exp_st}, rd);
      rdr(8'h00);
      chk("cause after source", cause_exp(), rd);
    end
    global_irq_enable <= 1'b1;
    asleep <= 1'b1;
    current_pc <= 13'h0200;
    pulse(6'h20, 1'b1);
    instr_retired <= 1'b1;
    @(posedge clk);
    instr_retired <= 1'b0;
    #1;
    chk("vector push", 32'h1, 32'({pc_cmd.push, pc_cmd.load} == 2'h3));
    chk("vector target", 32'h4, 32'(pc_cmd.target));
    chk("vector return", 32'h202, 32'(pc_cmd.ret));
    @(posedge clk);
    asleep <= 1'b0;
    global_irq_enable <= 1'b0;
    // Mask resets to zero, so every status bit is held back
    chk("irq masked", 32'h0, 32'(irq));
    rdr(8'h08);
    chk("irq status", 32'h7F, rd);
    wr(8'h0C, 8'h7F);
    settle;
    chk("irq raised", 32'h1, 32'(irq));
    rdr(8'h0C);
    chk("irq mask", 32'h7F, rd);
    wr(8'h08, 8'h7F);
    rdr(8'h08);
    chk("irq status cleared", 32'h0, rd);
    chk("irq idle", 32'h0, 32'(irq));
    wr(8'h0C, 8'h00);
    rdr(8'h10);
    chk("unmapped read", 32'h2, {30'h0, rsp});
    chk("unmapped data", 32'h0, rd);
    wr(8'h14, 8'h55);
    chk("unmapped write", 32'h2, {30'h0, rsp});
    give_verdict;
  end
endmodule
`default_nettype wire
